/* File: design/iphc_pkg.sv */
// Notes on behaviour
// - While over-voltage is reported, both drive outputs stay off.
// - Over-voltage is flagged to the on-time processing so idle time is not dead time.
// - Power-good is high only in normal regulated operation, low otherwise.
// - Start-up latch is set in every off phase; power-good low while it is set.
// - Start-up latch clears when the error amplifier stops charging its capacitor.
// - Power-good is forced low when off or on any fault.
// - A divider steers sync pulses alternately to phase one then phase two.
// - Sync arms the selected phase latch; its clock rises on sync falling edge.
// - A phase clock is cleared by the rising edge of that phase's driver.
// - A pending clock sets the driver only after the coil is demagnetized.
// - Discharge is extended while the selected phase clock waits for its driver.
// - Demag latch sets on zero-current indication, clears when the next drive pulse starts.
// - A driver low for over 200 us sets its demag latch via a watchdog.
// - While in-rush is reported, neither driver may turn on.
`default_nettype none
package iphc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WDOG_TIME_US = 200;
  localparam int WDOG_CYC = WDOG_TIME_US * CLK_MHZ;
  localparam int WDOG_W = 15;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int INT_W = 4;
  localparam int INT_OVP_BIT = 0;
  localparam int INT_FAULT_BIT = 1;
  localparam int INT_PG_FALL_BIT = 2;
  localparam int INT_WDOG_BIT = 3;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;
  localparam int STATUS_W = 11;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic sync;
    logic [1:0] zcd;
    logic ovp;
    logic ea_charging;
    logic inrush;
    logic fault;
    logic [1:0] ton_end;
  } iphc_cmp_s;
  localparam int CMP_W = $bits(iphc_cmp_s);
endpackage : iphc_pkg
`default_nettype wire

/* File: design/iphc_top.sv */
`default_nettype none
module iphc_sync
  import iphc_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : iphc_sync

module iphc_top
  import iphc_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SYNC,
  input wire logic [1:0] ZCD,
  input wire logic OVP,
  input wire logic EA_CHARGING,
  input wire logic INRUSH,
  input wire logic FAULT,
  input wire logic [1:0] TON_END,
  output logic [1:0] DRIVE,
  output logic PHASE_ONE_CLOCK,
  output logic PHASE_TWO_CLOCK,
  output logic OSC_HOLD,
  output logic TON_OVP,
  output logic POWER_GOOD,
  output logic IRQ
);
  iphc_cmp_s cmp_raw;
  iphc_cmp_s cmp;
  logic sync_q;
  logic ea_q;
  logic enable;
  logic phase_sel;
  logic [1:0] armed;
  logic [1:0] phase_clock;
  logic [1:0] drive;
  logic [1:0] drive_q;
  logic [1:0] demag_latch;
  logic startup_latch;
  logic power_good;
  logic next_phase_sel;
  logic [1:0] next_armed;
  logic [1:0] next_phase_clock;
  logic [1:0] next_drive;
  logic [1:0] next_demag_latch;
  logic next_startup_latch;
  logic next_power_good;
  logic [1:0] drive_rise;
  logic [1:0] wdog_fire;
  logic sync_rise;
  logic sync_fall;
  logic ea_fall;
  logic off_state;
  logic fault_any;

  // Every comparator output is asynchronous to CLK, so all pass two flops first.
  assign cmp_raw = '{sync: SYNC, zcd: ZCD, ovp: OVP, ea_charging: EA_CHARGING,
                     inrush: INRUSH, fault: FAULT, ton_end: TON_END};

  iphc_sync #(
    .W(CMP_W)
  ) u_cmp_sync (
    .clk(CLK),
    .reset(RESET),
    .d(cmp_raw),
    .q(cmp)
  );

  assign off_state = !enable;
  assign fault_any = cmp.fault | cmp.ovp;
  assign sync_rise = cmp.sync & !sync_q;
  assign sync_fall = !cmp.sync & sync_q;
  assign ea_fall = !cmp.ea_charging & ea_q;
  assign drive_rise = drive & ~drive_q;

  always_comb begin
    next_phase_sel = phase_sel;
    next_armed = armed;
    next_phase_clock = phase_clock;
    next_drive = drive;
    next_demag_latch = demag_latch;
    next_startup_latch = startup_latch;
    next_power_good = 1'b0;
    if (sync_rise) begin
      next_armed[phase_sel] = 1'b1;
      next_phase_sel = !phase_sel;
    end
    for (int p = 0; p < 2; p++) begin
      if (sync_fall && armed[p]) begin
        next_armed[p] = 1'b0;
        next_phase_clock[p] = 1'b1;
      end else if (drive_rise[p]) begin
        next_phase_clock[p] = 1'b0;
      end
      // The demag set wins over the clear so a zero-current edge is never lost.
      if (drive_rise[p]) begin
        next_demag_latch[p] = 1'b0;
      end
      if (cmp.zcd[p] || wdog_fire[p]) begin
        next_demag_latch[p] = 1'b1;
      end
      if (off_state || cmp.ovp) begin
        next_drive[p] = 1'b0;
      end else if (drive[p]) begin
        if (cmp.ton_end[p]) begin
          next_drive[p] = 1'b0;
        end
      end else if (phase_clock[p] && demag_latch[p] && !cmp.inrush) begin
        next_drive[p] = 1'b1;
      end
    end
    if (off_state) begin
      next_phase_sel = 1'b0;
      next_armed = 2'b00;
      next_phase_clock = 2'b00;
      next_startup_latch = 1'b1;
    end else if (ea_fall) begin
      next_startup_latch = 1'b0;
    end
    if (enable && !startup_latch && !fault_any) begin
      next_power_good = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync_q <= 1'b0;
      ea_q <= 1'b0;
      phase_sel <= 1'b0;
      armed <= 2'b00;
      phase_clock <= 2'b00;
      drive <= 2'b00;
      drive_q <= 2'b00;
      demag_latch <= 2'b00;
      startup_latch <= 1'b1;
      power_good <= 1'b0;
    end else begin
      sync_q <= cmp.sync;
      ea_q <= cmp.ea_charging;
      phase_sel <= next_phase_sel;
      armed <= next_armed;
      phase_clock <= next_phase_clock;
      drive <= next_drive;
      drive_q <= drive;
      demag_latch <= next_demag_latch;
      startup_latch <= next_startup_latch;
      power_good <= next_power_good;
    end
  end

  // Watchdog per phase: without it a cold start never sees a zero-current edge.
  logic [WDOG_W-1:0] wdog_cnt [2];
  logic [WDOG_W-1:0] next_wdog_cnt [2];

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      wdog_fire[p] = 1'b0;
      next_wdog_cnt[p] = wdog_cnt[p];
      if (drive[p]) begin
        next_wdog_cnt[p] = '0;
      end else if (wdog_cnt[p] >= WDOG_W'(WDOG_CYCLES - 1)) begin
        wdog_fire[p] = 1'b1;
        next_wdog_cnt[p] = '0;
      end else begin
        next_wdog_cnt[p] = wdog_cnt[p] + WDOG_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wdog_cnt[0] <= '0;
      wdog_cnt[1] <= '0;
    end else begin
      wdog_cnt[0] <= next_wdog_cnt[0];
      wdog_cnt[1] <= next_wdog_cnt[1];
    end
  end

  // AHB-Lite slave with zero wait states; read data is registered in the address phase.
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_event;
  logic ovp_q;
  logic fault_q;
  logic pg_q;
  logic [31:0] rdata;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic next_enable;
  logic [INT_W-1:0] next_int_stat;
  logic [INT_W-1:0] next_int_mask;
  logic [31:0] next_rdata;
  logic access;
  logic [STATUS_W-1:0] status;

  assign access = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);
  assign status = {cmp.ovp, demag_latch, drive, phase_clock, phase_sel, startup_latch,
                   power_good, enable};

  always_comb begin
    int_event = '0;
    int_event[INT_OVP_BIT] = cmp.ovp & !ovp_q;
    int_event[INT_FAULT_BIT] = cmp.fault & !fault_q;
    int_event[INT_PG_FALL_BIT] = !power_good & pg_q;
    int_event[INT_WDOG_BIT] = |wdog_fire;
    next_wr_pend = access && HWRITE;
    next_wr_addr = HADDR[7:0];
    next_enable = enable;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    next_rdata = '0;
    if (access && !HWRITE) begin
      case (HADDR[7:0])
        ADDR_CTRL: next_rdata[CTRL_ENABLE_BIT] = enable;
        ADDR_STATUS: next_rdata[STATUS_W-1:0] = status;
        ADDR_INT_STAT: begin
          next_rdata[INT_W-1:0] = int_stat;
          next_int_stat = '0;
        end
        ADDR_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
        default: next_rdata = '0;
      endcase
    end
    if (wr_pend) begin
      case (wr_addr)
        ADDR_CTRL: next_enable = HWDATA[CTRL_ENABLE_BIT];
        ADDR_INT_MASK: next_int_mask = HWDATA[INT_W-1:0];
        default: next_enable = enable;
      endcase
    end
    // A new event in the read-clear cycle survives the clear.
    next_int_stat = next_int_stat | int_event;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      enable <= CTRL_RESET;
      int_stat <= '0;
      int_mask <= INT_MASK_RESET;
      ovp_q <= 1'b0;
      fault_q <= 1'b0;
      pg_q <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      enable <= next_enable;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      ovp_q <= cmp.ovp;
      fault_q <= cmp.fault;
      pg_q <= power_good;
      rdata <= next_rdata;
    end
  end

  assign HRDATA = rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(int_stat & int_mask);
  assign DRIVE = drive;
  assign PHASE_ONE_CLOCK = phase_clock[0];
  assign PHASE_TWO_CLOCK = phase_clock[1];
  // The oscillator keeps discharging while the clock it just issued has not turned its driver on.
  assign OSC_HOLD = |(phase_clock & ~drive);
  assign TON_OVP = cmp.ovp;
  assign POWER_GOOD = power_good;
endmodule : iphc_top
`default_nettype wire

/* File: tb/iphc_assertions.sv */
`default_nettype none
module iphc_assertions (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic OVP,
  input wire logic FAULT,
  input wire logic INRUSH,
  input wire logic [1:0] DRIVE,
  input wire logic PHASE_ONE_CLOCK,
  input wire logic PHASE_TWO_CLOCK,
  input wire logic TON_OVP,
  input wire logic POWER_GOOD,
  input wire logic HREADYOUT,
  input wire logic HRESP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Five samples leave room for the two synchronizer stages and the output flop.
  chk_ovp_drive_off: assert property (OVP [*5] |-> DRIVE == 2'h0)
    else $error("drive on during over-voltage");
  chk_ovp_notice: assert property (OVP [*5] |-> TON_OVP)
    else $error("over-voltage notice missing");
  chk_pg_fault_low: assert property ((OVP || FAULT) [*5] |-> !POWER_GOOD)
    else $error("power good high during fault");
  chk_clock_excl: assert property (!(PHASE_ONE_CLOCK && PHASE_TWO_CLOCK))
    else $error("both phase clocks high");
  chk_clock_clear: assert property ($rose(DRIVE[0]) |-> ##[1:2] !PHASE_ONE_CLOCK)
    else $error("phase one clock not cleared");
  chk_drive_after_clk: assert property ($rose(DRIVE[1]) |-> PHASE_TWO_CLOCK)
    else $error("phase two drive without clock");
  chk_inrush_hold: assert property (INRUSH [*5] |-> !$rose(DRIVE[0]) && !$rose(DRIVE[1]))
    else $error("drive turned on during in-rush");
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
  // Power-good is registered behind the two synchronizer stages, so a rise reflects inputs three samples back.
  chk_pg_rise_clean: assert property ($rose(POWER_GOOD) |-> !$past(OVP, 3) && !$past(FAULT, 3))
    else $error("power good rose during fault");
  cover property ($rose(POWER_GOOD));
  cover property ($rose(PHASE_TWO_CLOCK));
  cover property ($rose(TON_OVP));
endmodule : iphc_assertions
bind iphc_top iphc_assertions i_chk (.CLK, .RESET, .OVP, .FAULT, .INRUSH, .DRIVE, .PHASE_ONE_CLOCK,
  .PHASE_TWO_CLOCK, .TON_OVP, .POWER_GOOD, .HREADYOUT, .HRESP);
`default_nettype wire

/* File: tb/iphc_stage.sv */
`default_nettype none
module iphc_stage (
  input wire logic clk,
  input wire logic [1:0] drive,
  input wire logic pg,
  input wire logic [7:0] ton,
  input wire logic mute,
  output logic [1:0] ton_end,
  output logic [1:0] zcd,
  output logic run
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt [2];
  logic [1:0] drv_q;
  initial begin
    ton_end = 2'h0;
    zcd = 2'h0;
    drv_q = 2'h0;
    run = 1'b0;
    cnt[0] = 8'hFF;
    cnt[1] = 8'hFF;
  end
  always @(posedge clk) begin
    drv_q <= drive;
    run <= pg;
    for (int i = 0; i < 2; i++) begin
      // Counter restarts on every drive edge and saturates so idle phases stay quiet.
      cnt[i] <= (drive[i] != drv_q[i]) ? 8'h00 : cnt[i] + {7'h0, cnt[i] != 8'hFF};
      ton_end[i] <= drive[i] && cnt[i] >= ton;
      // A high mute keeps the winding silent, so only the watchdog can release a waiting phase.
      zcd[i] <= !mute && !drive[i] && cnt[i] < 8'h03;
    end
  end
endmodule : iphc_stage
`default_nettype wire

/* File: tb/test_interleaved_phase_clock.sv */
`default_nettype none
module test_interleaved_phase_clock;
  import iphc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d;} iphc_row_s;
  logic CLK, RESET, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, SYNC, OVP, EA_CHARGING, INRUSH, FAULT;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, ZCD, TON_END, DRIVE;
  logic [2:0] HSIZE;
  logic PHASE_ONE_CLOCK, PHASE_TWO_CLOCK, OSC_HOLD, TON_OVP, POWER_GOOD, IRQ, run, mute;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  iphc_row_s rows [5] = '{'{ADDR_CTRL, 32'h0}, '{ADDR_STATUS, 32'h4}, '{ADDR_INT_STAT, 32'h0},
    '{ADDR_INT_MASK, 32'h0}, '{8'h10, 32'h0}};
  assign HREADY = HREADYOUT;
  iphc_top #(.WDOG_CYCLES(50)) i_dut (.CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SYNC, .ZCD, .OVP, .EA_CHARGING, .INRUSH, .FAULT, .TON_END,
    .DRIVE, .PHASE_ONE_CLOCK, .PHASE_TWO_CLOCK, .OSC_HOLD, .TON_OVP, .POWER_GOOD, .IRQ);
  iphc_stage i_stage (.clk(CLK), .drive(DRIVE), .pg(POWER_GOOD), .ton(8'h05), .ton_end(TON_END),
    .zcd(ZCD), .run(run), .mute(mute));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    HSIZE <= HSIZE_WORD;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus
  // Pulses are spaced by a whole drive cycle, far slower than the oscillator limit.
  task automatic syncp();
    SYNC <= 1'b1;
    repeat (4) @(posedge CLK);
    SYNC <= 1'b0;
  endtask : syncp
  // A blocked phase is expected to show no drive for the whole bounded wait.
  task automatic waitd(input logic [1:0] exp);
    n = 0;
    while (DRIVE === 2'h0 && n < 60) begin
      @(posedge CLK);
      n++;
    end
    chk({30'h0, DRIVE}, {30'h0, exp});
    while (DRIVE !== 2'h0 && n < 200) begin
      @(posedge CLK);
      n++;
    end
  endtask : waitd
  task automatic summarize();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    summarize();
  end
  initial begin
    {RESET, EA_CHARGING} = 2'h3;
    {HSEL, HWRITE, SYNC, OVP, INRUSH, FAULT, mute} = 7'h0;
    {HADDR, HWDATA, HTRANS, HSIZE} = 69'h0;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
    end
    $display("reset values done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (6) @(posedge CLK);
    chk({31'h0, POWER_GOOD}, 32'h0);
    EA_CHARGING <= 1'b0;
    repeat (8) @(posedge CLK);
    chk({31'h0, POWER_GOOD}, 32'h1);
    chk({31'h0, run}, 32'h1);
    $display("start-up done");
    repeat (60) @(posedge CLK);
    syncp();
    waitd(2'h1);
    syncp();
    waitd(2'h2);
    syncp();
    mute <= 1'b1;
    waitd(2'h1);
    syncp();
    waitd(2'h2);
    // With the winding muted, phase one's clock must wait for the watchdog to flag demagnetization.
    syncp();
    repeat (10) @(posedge CLK);
    chk({30'h0, DRIVE}, 32'h0);
    chk({31'h0, PHASE_ONE_CLOCK}, 32'h1);
    waitd(2'h1);
    mute <= 1'b0;
    $display("alternation done");
    bus(1'b1, ADDR_INT_MASK, 32'h1);
    OVP <= 1'b1;
    syncp();
    waitd(2'h0);
    chk({31'h0, TON_OVP}, 32'h1);
    chk({31'h0, POWER_GOOD}, 32'h0);
    chk({31'h0, IRQ}, 32'h1);
    bus(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd, 32'hD);
    chk({31'h0, IRQ}, 32'h0);
    OVP <= 1'b0;
    waitd(2'h2);
    $display("over-voltage done");
    INRUSH <= 1'b1;
    syncp();
    waitd(2'h0);
    chk({30'h0, OSC_HOLD, PHASE_ONE_CLOCK}, 32'h3);
    INRUSH <= 1'b0;
    waitd(2'h1);
    FAULT <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({31'h0, POWER_GOOD}, 32'h0);
    FAULT <= 1'b0;
    $display("hold and fault done");
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (4) @(posedge CLK);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h4);
    chk({31'h0, POWER_GOOD}, 32'h0);
    $display("off state done");
    summarize();
  end
endmodule : test_interleaved_phase_clock
`default_nettype wire
